/* File: include/ssr_pkg.sv */
package ssr_pkg;

	// Register byte offsets on the APB bus
	localparam logic [7:0] OPER_COND_OFS  = 8'h00;
	localparam logic [7:0] OPER_EN_OFS    = 8'h04;
	localparam logic [7:0] OPER_EVT_OFS   = 8'h08;
	localparam logic [7:0] PRESET_OFS     = 8'h0c;
	localparam logic [7:0] PROT_COND_OFS  = 8'h10;
	localparam logic [7:0] PROT_EN_OFS    = 8'h14;
	localparam logic [7:0] PROT_EVT_OFS   = 8'h18;
	localparam logic [7:0] PROT_SEL_OFS   = 8'h1c;
	localparam logic [7:0] QUES_COND_OFS  = 8'h20;
	localparam logic [7:0] QUES_EN_OFS    = 8'h24;
	localparam logic [7:0] QUES_EVT_OFS   = 8'h28;

	// Widths
	localparam int MASK_W = 16;
	localparam int PROT_W = 8;

	// Values after reset, the preset fill and the zero read word
	localparam logic [MASK_W-1:0] OPER_EN_RST  = 16'h0000;
	localparam logic [MASK_W-1:0] QUES_EN_RST  = 16'h0000;
	localparam logic [PROT_W-1:0] PROT_EN_RST  = 8'h00;
	localparam logic [PROT_W-1:0] PROT_SEL_RST = 8'hff;
	localparam logic [MASK_W-1:0] MASK_ALL_ONE = 16'hffff;
	localparam logic [31:0]       ZERO_WORD    = 32'h0000_0000;

	// Read word from a narrow field
	function automatic logic [31:0] ssr_zext16(input logic [MASK_W-1:0] v);
		ssr_zext16 = {16'h0000, v};
	endfunction

	function automatic logic [31:0] ssr_zext8(input logic [PROT_W-1:0] v);
		ssr_zext8 = {24'h000000, v};
	endfunction

endpackage

/* File: include/ssr_prot_if.sv */
`timescale 1ns/1ps
// Protection group signals between register file and event logic
interface ssr_prot_if;
	import ssr_pkg::*;
	logic [PROT_W-1:0] cond;
	logic [PROT_W-1:0] event_bits;
	logic              rd_clear;
	logic [PROT_W-1:0] enable_mask;
	logic [PROT_W-1:0] select_mask;
	logic              summary;
	logic              flag;

	modport regs (
		input  cond,
		input  event_bits,
		input  summary,
		input  flag,
		output rd_clear,
		output enable_mask,
		output select_mask
	);
	modport evt (
		output cond,
		output event_bits,
		output summary,
		output flag,
		input  rd_clear,
		input  enable_mask,
		input  select_mask
	);
endinterface

/* File: rtl/ssr_prot_evt.sv */
`timescale 1ns/1ps
// Protection condition, latched events and summary outputs
module ssr_prot_evt
	import ssr_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic [PROT_W-1:0] fault_in,
	ssr_prot_if.evt                pif
);
	logic [PROT_W-1:0] cond_s;
	logic [PROT_W-1:0] cond_prev_q;
	logic [PROT_W-1:0] evt_q;
	logic [PROT_W-1:0] evt_d;
	logic [PROT_W-1:0] evt_shown_q;
	logic [PROT_W-1:0] rise;

	ssr_sync u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     (fault_in),
		.dout    (cond_s)
	);

	// Rising edges; set beats the read clear
	// A read clears only what its setup captured, so a late event waits for the next read
	assign rise  = cond_s & ~cond_prev_q;
	assign evt_d = (evt_q & ~(pif.rd_clear ? evt_shown_q : '0)) | rise;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cond_prev_q <= '0;
			evt_q       <= '0;
			evt_shown_q <= '0;
		end else begin
			cond_prev_q <= cond_s;
			evt_q       <= evt_d;
			evt_shown_q <= evt_q;
		end
	end

	assign pif.cond       = cond_s;
	assign pif.event_bits = evt_q;
	assign pif.summary    = |(evt_q & pif.enable_mask);
	assign pif.flag       = |(evt_q & pif.select_mask);
endmodule

/* File: rtl/ssr_status_regs.sv */
`timescale 1ns/1ps
// How it works
// RULE1 - Operation condition reads always return zero.
// RULE2 - Operation enable mask is stored but drives nothing.
// RULE3 - Operation enable read returns the last stored mask.
// RULE4 - Operation event reads always return zero.
// RULE5 - Preset loads operation and questionable enable masks with all ones.
// RULE6 - Protection condition read returns live power stage status bits.
// RULE7 - Writable protection enable mask gates events into protection summary.
// RULE8 - Protection enable read returns the stored mask.
// RULE9 - Protection event read returns the latched fault bits.
// RULE10 - Status byte protection flag needs an event bit and its select bit.
// RULE11 - Fault-select mask resets to 255 and changes only when written.
// RULE12 - Fault-select read returns last written value or the reset default.
// RULE13 - Questionable condition reads always return zero.
// RULE14 - Questionable enable mask is stored but drives nothing.
// RULE15 - Questionable event reads always return zero.
// RULE16 - Protection events latch on rising condition, cleared by their read.
module ssr_status_regs
	import ssr_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	input  wire logic [PROT_W-1:0] fault_in,
	output logic                   prot_summary,
	output logic                   prot_flag
);
	ssr_prot_if pif ();

	logic [MASK_W-1:0] oper_en_q;
	logic [MASK_W-1:0] ques_en_q;
	logic [PROT_W-1:0] prot_en_q;
	logic [PROT_W-1:0] prot_sel_q;
	logic [31:0]       rdata_d;
	logic [31:0]       prdata_q;
	logic              err_d;
	logic              pslverr_q;

	// Bus decode
	wire access   = psel & penable;
	wire wr_en    = access & pwrite;
	wire rd_en    = access & ~pwrite;
	wire hit_oc   = (paddr == OPER_COND_OFS);
	wire hit_oen  = (paddr == OPER_EN_OFS);
	wire hit_oev  = (paddr == OPER_EVT_OFS);
	wire hit_pre  = (paddr == PRESET_OFS);
	wire hit_pc   = (paddr == PROT_COND_OFS);
	wire hit_pen  = (paddr == PROT_EN_OFS);
	wire hit_pev  = (paddr == PROT_EVT_OFS);
	wire hit_psel = (paddr == PROT_SEL_OFS);
	wire hit_qc   = (paddr == QUES_COND_OFS);
	wire hit_qen  = (paddr == QUES_EN_OFS);
	wire hit_qev  = (paddr == QUES_EVT_OFS);
	wire mapped   = hit_oc | hit_oen | hit_oev | hit_pre | hit_pc | hit_pen
	              | hit_pev | hit_psel | hit_qc | hit_qen | hit_qev;
	// Preset is a command: any write to its slot triggers it
	wire preset   = wr_en & hit_pre;

	ssr_prot_evt u_evt (
		.pclk     (pclk),
		.presetn  (presetn),
		.fault_in (fault_in),
		.pif      (pif)
	);

	// RULE16 read clear
	// Clear only on the completing read so a held access is not counted twice
	assign pif.rd_clear    = rd_en & hit_pev;
	// RULE7 mask to summary
	assign pif.enable_mask = prot_en_q;
	// RULE10 select mask gating
	assign pif.select_mask = prot_sel_q;
	assign prot_summary    = pif.summary;
	assign prot_flag       = pif.flag;

	// Read mux; zero slots are hardwired, masks kept elsewhere never steer them
	always_comb begin
		rdata_d = ZERO_WORD;
		err_d   = 1'b0;
		unique case (1'b1)
			// RULE1 oper cond zero
			hit_oc:   rdata_d = ZERO_WORD;
			// RULE3 oper enable readback
			hit_oen:  rdata_d = ssr_zext16(oper_en_q);
			// RULE4 oper event zero
			hit_oev:  rdata_d = ZERO_WORD;
			hit_pre:  rdata_d = ZERO_WORD;
			// RULE6 live condition read
			hit_pc:   rdata_d = ssr_zext8(pif.cond);
			// RULE8 prot enable readback
			hit_pen:  rdata_d = ssr_zext8(prot_en_q);
			// RULE9 latched event read
			hit_pev:  rdata_d = ssr_zext8(pif.event_bits);
			// RULE12 select readback
			hit_psel: rdata_d = ssr_zext8(prot_sel_q);
			// RULE13 ques cond zero
			hit_qc:   rdata_d = ZERO_WORD;
			hit_qen:  rdata_d = ssr_zext16(ques_en_q);
			// RULE15 ques event zero
			hit_qev:  rdata_d = ZERO_WORD;
			default:  err_d   = 1'b1;
		endcase
	end

	// RULE2 oper enable store
	// RULE5 preset to all ones
	// RULE14 ques enable store
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oper_en_q <= OPER_EN_RST;
			ques_en_q <= QUES_EN_RST;
		end else if (preset) begin
			oper_en_q <= MASK_ALL_ONE;
			ques_en_q <= MASK_ALL_ONE;
		end else begin
			if (wr_en && hit_oen)
				oper_en_q <= pwdata[MASK_W-1:0];
			if (wr_en && hit_qen)
				ques_en_q <= pwdata[MASK_W-1:0];
		end
	end

	// RULE7 prot enable store
	// RULE11 select held until written
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prot_en_q  <= PROT_EN_RST;
			prot_sel_q <= PROT_SEL_RST;
		end else begin
			if (wr_en && hit_pen)
				prot_en_q <= pwdata[PROT_W-1:0];
			if (wr_en && hit_psel)
				prot_sel_q <= pwdata[PROT_W-1:0];
		end
	end

	// Read data registered in setup, so the access phase needs no wait state
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_q  <= ZERO_WORD;
			pslverr_q <= 1'b0;
		end else if (psel && !penable) begin
			prdata_q  <= pwrite ? ZERO_WORD : rdata_d;
			pslverr_q <= err_d;
		end
	end

	assign prdata  = prdata_q;
	assign pready  = 1'b1;
	assign pslverr = pslverr_q & access;

	// Fixed-zero slots: no stored mask may leak into these reads
	// RULE1 oper cond zero
	chk_oper_cond_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
		rd_en && hit_oc |-> prdata == ZERO_WORD)
		else $error("operation condition read not zero");

	// RULE4 oper event zero
	chk_oper_evt_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
		rd_en && hit_oev |-> prdata == ZERO_WORD)
		else $error("operation event read not zero");

	// RULE13 ques cond zero
	chk_ques_cond_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
		rd_en && hit_qc |-> prdata == ZERO_WORD)
		else $error("questionable condition read not zero");

	// RULE15 ques event zero
	chk_ques_evt_zero: assert property (@(posedge pclk) disable iff (!presetn) // RULE15
		rd_en && hit_qev |-> prdata == ZERO_WORD)
		else $error("questionable event read not zero");

	// Stored masks: writes and preset land, nothing else moves them, reads echo them
	// RULE3 oper enable readback
	chk_oper_en_back: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
		rd_en && hit_oen |-> prdata == ssr_zext16(oper_en_q))
		else $error("operation enable readback wrong");

	// RULE2 oper enable store
	chk_oper_en_store: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
		wr_en && hit_oen |=> oper_en_q == $past(pwdata[MASK_W-1:0]))
		else $error("operation enable write not stored");

	// RULE3 oper enable held
	chk_oper_en_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE3
		!(wr_en && (hit_oen || hit_pre)) |=> $stable(oper_en_q))
		else $error("operation enable changed without write");

	// RULE14 ques enable store
	chk_ques_en_store: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
		wr_en && hit_qen |=> ques_en_q == $past(pwdata[MASK_W-1:0]))
		else $error("questionable enable write not stored");

	// RULE14 ques enable held
	chk_ques_en_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
		!(wr_en && (hit_qen || hit_pre)) |=> $stable(ques_en_q))
		else $error("questionable enable changed without write");

	// RULE14 ques enable readback
	chk_ques_en_back: assert property (@(posedge pclk) disable iff (!presetn) // RULE14
		rd_en && hit_qen |-> prdata == ssr_zext16(ques_en_q))
		else $error("questionable enable readback wrong");

	// RULE5 preset all ones
	chk_preset_ones: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
		preset |=> oper_en_q == MASK_ALL_ONE && ques_en_q == MASK_ALL_ONE)
		else $error("preset did not set masks");

	// RULE11 preset spares select
	chk_preset_keeps: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
		preset |=> $stable(prot_en_q) && $stable(prot_sel_q))
		else $error("preset touched protection masks");

	// RULE7 prot enable store
	chk_prot_en_store: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
		wr_en && hit_pen |=> prot_en_q == $past(pwdata[PROT_W-1:0]))
		else $error("protection enable write not stored");

	// RULE8 prot enable held
	chk_prot_en_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
		!(wr_en && hit_pen) |=> $stable(prot_en_q))
		else $error("protection enable changed without write");

	// RULE8 prot enable readback
	chk_prot_en_back: assert property (@(posedge pclk) disable iff (!presetn) // RULE8
		rd_en && hit_pen |-> prdata == ssr_zext8(prot_en_q))
		else $error("protection enable readback wrong");

	// RULE11 select stable
	chk_sel_stable: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
		!(wr_en && hit_psel) |=> $stable(prot_sel_q))
		else $error("select mask changed without write");

	// RULE11 select after reset
	chk_sel_reset: assert property (@(posedge pclk) // RULE11
		$rose(presetn) |-> prot_sel_q == PROT_SEL_RST)
		else $error("select mask not at power-on value");

	// Enable masks come out of reset cleared
	chk_mask_reset: assert property (@(posedge pclk)
		$rose(presetn) |-> oper_en_q == OPER_EN_RST && ques_en_q == QUES_EN_RST
			&& prot_en_q == PROT_EN_RST)
		else $error("enable masks not cleared by reset");

	// RULE12 select store
	chk_sel_store: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
		wr_en && hit_psel |=> prot_sel_q == $past(pwdata[PROT_W-1:0]))
		else $error("select mask write not stored");

	// RULE12 select readback
	chk_sel_back: assert property (@(posedge pclk) disable iff (!presetn) // RULE12
		rd_en && hit_psel |-> prdata == ssr_zext8(prot_sel_q))
		else $error("select mask readback wrong");

	// Protection events; the read word was captured in setup, one cycle old
	// RULE6 live condition read
	chk_cond_live: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
		rd_en && hit_pc |-> prdata == ssr_zext8($past(pif.cond)))
		else $error("protection condition read mismatch");

	// RULE9 event read value
	chk_evt_read: assert property (@(posedge pclk) disable iff (!presetn) // RULE9
		rd_en && hit_pev |-> prdata == ssr_zext8($past(pif.event_bits)))
		else $error("protection event read mismatch");

	// RULE16 rise latches
	chk_evt_set: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
		(pif.event_bits & $past(pif.cond) & ~$past(pif.cond, 2))
			== ($past(pif.cond) & ~$past(pif.cond, 2)))
		else $error("rising condition did not latch an event");

	// RULE16 only rises set
	chk_evt_only_rise: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
		(pif.event_bits & ~$past(pif.event_bits)
			& ~($past(pif.cond) & ~$past(pif.cond, 2))) == '0)
		else $error("protection event set without rising condition");

	// RULE16 held until read
	chk_evt_hold: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
		!pif.rd_clear |=> (pif.event_bits & $past(pif.event_bits))
			== $past(pif.event_bits))
		else $error("protection event lost without a read");

	// RULE16 returned bits clear
	chk_evt_clear: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
		pif.rd_clear |=> (pif.event_bits & $past(prdata[PROT_W-1:0])
			& ~($past(pif.cond) & ~$past(pif.cond, 2))) == '0)
		else $error("protection event not cleared by read");

	// RULE16 unread bits survive
	chk_evt_keep_new: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
		pif.rd_clear |=> (pif.event_bits & $past(pif.event_bits & ~prdata[PROT_W-1:0]))
			== $past(pif.event_bits & ~prdata[PROT_W-1:0]))
		else $error("unreported protection event cleared");

	// RULE16 clear only on read
	chk_rd_clear_only: assert property (@(posedge pclk) disable iff (!presetn) // RULE16
		pif.rd_clear |-> rd_en && hit_pev)
		else $error("event clear outside an event read");

	// RULE7 summary gating
	chk_summary_gate: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
		prot_summary |-> (pif.event_bits & prot_en_q) != '0)
		else $error("protection summary without enabled event");

	// RULE7 summary raised
	chk_summary_on: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
		(pif.event_bits & prot_en_q) != '0 |-> prot_summary)
		else $error("protection summary missing");

	// RULE10 flag needs select
	chk_flag_gate: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
		prot_flag |-> (pif.event_bits & prot_sel_q) != '0)
		else $error("protection flag without selected event");

	// RULE10 flag raised
	chk_flag_on: assert property (@(posedge pclk) disable iff (!presetn) // RULE10
		(pif.event_bits & prot_sel_q) != '0 |-> prot_flag)
		else $error("protection flag missing");

	// Bus answer: no wait states, so an error must show in the one access cycle
	chk_ready_high: assert property (@(posedge pclk) disable iff (!presetn)
		access |-> pready)
		else $error("access not answered at once");

	// Unmapped places answer with an error
	chk_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		access && !mapped |-> pslverr)
		else $error("unmapped access without error");

	// Mapped places never answer with an error
	chk_err_mapped: assert property (@(posedge pclk) disable iff (!presetn)
		access && mapped |-> !pslverr)
		else $error("error on a mapped access");

	// Error shows only in the access phase
	chk_err_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!access |-> !pslverr)
		else $error("error outside an access");

	// Writes return no data
	chk_wr_no_data: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en |-> prdata == ZERO_WORD)
		else $error("read data during a write");

	// Unmapped reads return zero
	chk_unmapped_zero: assert property (@(posedge pclk) disable iff (!presetn)
		rd_en && !mapped |-> prdata == ZERO_WORD)
		else $error("unmapped read not zero");
endmodule

/* File: rtl/ssr_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser for the power stage status bits
module ssr_sync
	import ssr_pkg::*;
(
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic [PROT_W-1:0] din,
	output logic      [PROT_W-1:0] dout
);
	logic [PROT_W-1:0] meta_q;

	// First stage feeds only the second
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			meta_q <= '0;
			dout   <= '0;
		end else begin
			meta_q <= din;
			dout   <= meta_q;
		end
	end
endmodule

/* File: tb/ssr_ctrl_model.sv */
`timescale 1ns/1ps
// Remote controller: issues status queries and settings over APB
module ssr_ctrl_model (
	input  wire logic        pclk,
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	// Bus idle from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end

	// Setup then access; answer taken at the rising edge that samples pready high
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No wait count assumed: only the bench watchdog ends a stall
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule

/* File: tb/ssr_status_regs_tb_top.sv */
`timescale 1ns/1ps
// Status register bench; the power stage fault lines are driven here
module ssr_status_regs_tb_top import ssr_pkg::*; ;
	logic              pclk;
	logic              presetn;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [7:0]        paddr;
	logic [31:0]       pwdata;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic [PROT_W-1:0] fault_in;
	logic              prot_summary;
	logic              prot_flag;
	int                errors;
	int                n_compared;

	// 10 MHz clock
	initial pclk = 1'b0;
	always #50 pclk = ~pclk;

	ssr_status_regs DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .fault_in(fault_in), .prot_summary(prot_summary),
		.prot_flag(prot_flag));
	ssr_ctrl_model ctl (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

	// Compare and count
	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic        e;
		ctl.xfer(1'b1, a, d, r, e);
	endtask

	task automatic rchk(input string name, input logic [7:0] a, input logic [31:0] exp);
		logic [31:0] r;
		logic        e;
		ctl.xfer(1'b0, a, 32'h0000_0000, r, e);
		chk(name, r, exp);
		chk({name, "_err"}, {31'h0, e}, ZERO_WORD);
	endtask

	// Flags sampled mid-cycle so the last write has landed
	task automatic flags(input logic s, input logic f);
		@(negedge pclk);
		chk("prot_summary", {31'h0, prot_summary}, {31'h0, s});
		chk("prot_flag", {31'h0, prot_flag}, {31'h0, f});
	endtask

	task automatic t_defaults;
		rchk("oper_en", OPER_EN_OFS, ZERO_WORD);
		rchk("ques_en", QUES_EN_OFS, ZERO_WORD);
		rchk("prot_en", PROT_EN_OFS, ZERO_WORD);
		rchk("prot_sel", PROT_SEL_OFS, 32'h0000_00ff);
	endtask

	// Masks stored and read back; zero registers stay zero after writes
	task automatic t_masks;
		wr(OPER_EN_OFS, 32'hdead_a5a5);
		wr(QUES_EN_OFS, 32'h0000_3c0f);
		wr(PROT_EN_OFS, 32'h0000_013c);
		wr(PROT_SEL_OFS, 32'h0000_005a);
		rchk("oper_en", OPER_EN_OFS, 32'h0000_a5a5);
		rchk("ques_en", QUES_EN_OFS, 32'h0000_3c0f);
		rchk("prot_en", PROT_EN_OFS, 32'h0000_003c);
		rchk("oper_cond", OPER_COND_OFS, ZERO_WORD);
		rchk("oper_evt", OPER_EVT_OFS, ZERO_WORD);
		rchk("ques_cond", QUES_COND_OFS, ZERO_WORD);
		rchk("ques_evt", QUES_EVT_OFS, ZERO_WORD);
		wr(PRESET_OFS, 32'h0000_0000);
		rchk("oper_en", OPER_EN_OFS, 32'h0000_ffff);
		rchk("ques_en", QUES_EN_OFS, 32'h0000_ffff);
		rchk("prot_sel", PROT_SEL_OFS, 32'h0000_005a);
		rchk("oper_cond", OPER_COND_OFS, ZERO_WORD);
	endtask

	// Fault latch, masking of summary and flag, read clears
	task automatic t_prot;
		wr(PROT_EN_OFS, 32'h0000_0080);
		wr(PROT_SEL_OFS, 32'h0000_0001);
		flags(1'b0, 1'b0);
		@(posedge pclk);
		fault_in <= 8'h81;
		repeat (5) @(posedge pclk);
		rchk("prot_cond", PROT_COND_OFS, 32'h0000_0081);
		flags(1'b1, 1'b1);
		wr(PROT_SEL_OFS, 32'h0000_0002);
		flags(1'b1, 1'b0);
		wr(PROT_EN_OFS, 32'h0000_0002);
		flags(1'b0, 1'b0);
		rchk("prot_evt", PROT_EVT_OFS, 32'h0000_0081);
		rchk("prot_evt", PROT_EVT_OFS, ZERO_WORD);
		wr(PROT_SEL_OFS, 32'h0000_00ff);
		flags(1'b0, 1'b0);
	endtask

	// Unmapped place: zero read data, and an error on both read and write
	task automatic t_unmapped;
		logic [31:0] r;
		logic        e;
		ctl.xfer(1'b0, 8'h40, 32'h0000_0000, r, e);
		chk("unmapped_rd", r, ZERO_WORD);
		chk("unmapped_rd_err", {31'h0, e}, 32'h0000_0001);
		ctl.xfer(1'b1, 8'h40, 32'hffff_ffff, r, e);
		chk("unmapped_wr_err", {31'h0, e}, 32'h0000_0001);
	endtask

	task automatic results;
		$display("errors=%0d compared=%0d", errors, n_compared);
		if (errors == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask

	// Main sequence after a 12-cycle reset
	initial begin
		errors = 0;
		n_compared = 0;
		presetn = 1'b0;
		fault_in = 8'h00;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		t_defaults();
		t_masks();
		t_prot();
		t_unmapped();
		results();
	end

	// Watchdog: the whole run needs well under 1000 cycles
	initial begin
		#500000;
		errors++;
		results();
	end
endmodule
